/* hw/tf_pkg.sv */
// constants shared by both ends of the seek / set-features command path
//
// Contract
// - command 7xh decodes as seek, low nibble ignored
// - seek accepted regardless of format state
// - lba split: snum, cyl lo, cyl hi, head
// - chs mode: cylinder hi/lo and head select
// - lba seek returns current address same split
// - command efh decodes as feature request
// - undefined feature code sets abort and error
// - 02h enables, 82h disables write cache
// - 55h disables, aah enables read look-ahead
// - 66h disables, cch enables default reverting
// - 05h enables, 85h disables power management
// - 06h/86h standby power-up, 07h spin-up
// - 09h enters, 89h leaves address-offset mode
// - 42h enables, c2h disables acoustic management
// - 43h records host interface sector time
// - reset: cache on, look-ahead on, reverting off
// - 03h: count upper five type, lower three
// - transfer types pio, flow pio, mdma, udma
// - full reassignment forces cache off, 02h no error
// - 10h/90h enable/disable serial sub-feature in count
// - sub-features 01h 02h 03h 04h 06h recognised
package tf_pkg;
    ////////////////////////////////////////////////////////////////////////////
    localparam logic [3:0] CMD_SEEK_NIB  = 4'h7;
    localparam logic [7:0] CMD_SET_FEAT  = 8'hef;
    localparam logic [7:0] FT_WC_ON      = 8'h02;
    localparam logic [7:0] FT_XFER       = 8'h03;
    localparam logic [7:0] FT_APM_ON     = 8'h05;
    localparam logic [7:0] FT_PUIS_ON    = 8'h06;
    localparam logic [7:0] FT_SPINUP     = 8'h07;
    localparam logic [7:0] FT_OFS_ON     = 8'h09;
    localparam logic [7:0] FT_SATA_ON    = 8'h10;
    localparam logic [7:0] FT_AAM_ON     = 8'h42;
    localparam logic [7:0] FT_HOST_TIME  = 8'h43;
    localparam logic [7:0] FT_LA_OFF     = 8'h55;
    localparam logic [7:0] FT_REVERT_OFF = 8'h66;
    localparam logic [7:0] FT_WC_OFF     = 8'h82;
    localparam logic [7:0] FT_APM_OFF    = 8'h85;
    localparam logic [7:0] FT_PUIS_OFF   = 8'h86;
    localparam logic [7:0] FT_OFS_OFF    = 8'h89;
    localparam logic [7:0] FT_SATA_OFF   = 8'h90;
    localparam logic [7:0] FT_LA_ON      = 8'haa;
    localparam logic [7:0] FT_AAM_OFF    = 8'hc2;
    localparam logic [7:0] FT_REVERT_ON  = 8'hcc;
    ////////////////////////////////////////////////////////////////////////////
    localparam logic [4:0] XT_PIO_DEF    = 5'h00;
    localparam logic [4:0] XT_PIO_FC     = 5'h01;
    localparam logic [4:0] XT_MDMA       = 5'h04;
    localparam logic [4:0] XT_UDMA       = 5'h08;
    localparam logic [2:0] PIO_DEF_MAX   = 3'h1;
    localparam logic [2:0] PIO_FC_MAX    = 3'h4;
    localparam logic [2:0] MDMA_MAX      = 3'h2;
    localparam logic [2:0] UDMA_MAX      = 3'h6;
    localparam logic [7:0] SF_BUF_OFS    = 8'h01;
    localparam logic [7:0] SF_AUTO_ACT   = 8'h02;
    localparam logic [7:0] SF_DIPM       = 8'h03;
    localparam logic [7:0] SF_IN_ORDER   = 8'h04;
    localparam logic [7:0] SF_PRESERVE   = 8'h06;
    ////////////////////////////////////////////////////////////////////////////
    localparam int ST_BSY = 7;
    localparam int ST_RDY = 6;
    localparam int ST_DSC = 4;
    localparam int ST_ERR = 0;
    localparam int ER_IDN = 4;
    localparam int ER_ABT = 2;
    localparam int DH_LBA = 6;
    localparam logic [7:0] ST_RESET      = 8'h50;
    localparam logic       RST_WC        = 1'b1;
    localparam logic       RST_LA        = 1'b1;
    localparam logic       RST_REVERT    = 1'b0;
    localparam logic       RST_REL_INT   = 1'b0;
    ////////////////////////////////////////////////////////////////////////////
    localparam int CLK_PERIOD_NS = 10;
    localparam int SEEK_TIME_NS  = 2000;
    localparam int SEEK_CYCLES   = (SEEK_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [11:0] SEEK_CNT = 12'(SEEK_CYCLES);
    localparam logic [27:0] MAX_LBA  = 28'h0fff000;
    localparam logic [15:0] MAX_CYL  = 16'h3fff;
    ////////////////////////////////////////////////////////////////////////////
    localparam logic [7:0] A_FEAT = 8'h00;
    localparam logic [7:0] A_SCNT = 8'h04;
    localparam logic [7:0] A_SNUM = 8'h08;
    localparam logic [7:0] A_CLO  = 8'h0c;
    localparam logic [7:0] A_CHI  = 8'h10;
    localparam logic [7:0] A_DH   = 8'h14;
    localparam logic [7:0] A_CMD  = 8'h18;
    localparam logic [7:0] A_STAT = 8'h1c;
    localparam int HS_DONE = 16;
    localparam int HS_PEND = 17;
endpackage

/* hw/taskfile_if.sv */
// task-file link between host controller and drive command decoder
`timescale 1ns/1ps
interface taskfile_if;
    // host to drive
    logic       cmd_valid;
    logic [7:0] cmd;
    logic [7:0] feature;
    logic [7:0] sec_count;
    logic [7:0] sec_num;
    logic [7:0] cyl_lo;
    logic [7:0] cyl_hi;
    logic [7:0] dev_head;
    // drive to host
    logic       done;
    logic [7:0] status;
    logic [7:0] error;
    logic [7:0] ret_sec_num;
    logic [7:0] ret_cyl_lo;
    logic [7:0] ret_cyl_hi;
    logic [7:0] ret_dev_head;

    modport host (output cmd_valid, cmd, feature, sec_count, sec_num, cyl_lo, cyl_hi,
                  dev_head, input done, status, error, ret_sec_num, ret_cyl_lo,
                  ret_cyl_hi, ret_dev_head);
    modport dev  (input cmd_valid, cmd, feature, sec_count, sec_num, cyl_lo, cyl_hi,
                  dev_head, output done, status, error, ret_sec_num, ret_cyl_lo,
                  ret_cyl_hi, ret_dev_head);
endinterface

/* hw/disk_cmd_device.sv */
// drive-side decoder for seek and set-features commands
//
// Added by the designer: the register addresses and the Wishbone slave port.
`timescale 1ns/1ps
module disk_cmd_device
    import tf_pkg::*;
(
    // clock and reset
    input  wire logic        mclk,
    input  wire logic        rst_n,
    // task-file link
    taskfile_if.dev          tf,
    // drive condition
    input  wire logic        realloc_full,
    // seek request to servo
    output logic             seek_go_q,
    output logic [15:0]      seek_cyl_q,
    output logic [3:0]       seek_head_q,
    output logic [27:0]      cur_lba_q,
    // feature settings
    output logic             write_cache_q,
    output logic             look_ahead_q,
    output logic             revert_q,
    output logic             release_int_q,
    output logic             apm_en_q,
    output logic             puis_en_q,
    output logic             spinup_q,
    output logic             offset_mode_q,
    output logic             aam_en_q,
    output logic [4:0]       xfer_type_q,
    output logic [2:0]       xfer_mode_q,
    output logic             iordy_off_q,
    output logic [4:0]       sata_en_q,
    output logic [31:0]      host_time_q
);
    typedef enum logic [1:0] {
        S_IDLE = 2'b00,
        S_SEEK = 2'b01,
        S_DONE = 2'b11
    } state_t;

    state_t      state_q;
    state_t      state_d;
    logic [11:0] cnt_q;
    logic [7:0]  status_q;
    logic [7:0]  error_q;
    logic        done_q;
    logic [7:0]  r_snum_q;
    logic [7:0]  r_clo_q;
    logic [7:0]  r_chi_q;
    logic [7:0]  r_dh_q;
    logic [7:0]  fin_err_q;
    logic        lba_mode_q;
    logic        feat_ok;
    logic        xfer_ok;
    logic        sata_ok;
    logic [4:0]  sata_bit;

    ////////////////////////////////////////////////////////////////////////////
    // command decode; format state plays no part in seek acceptance
    wire        take     = tf.cmd_valid && (state_q == S_IDLE);
    wire        is_seek  = (tf.cmd[7:4] == CMD_SEEK_NIB);
    wire        is_feat  = (tf.cmd == CMD_SET_FEAT);
    wire        lba_sel  = tf.dev_head[DH_LBA];
    wire [27:0] tgt_lba  = {tf.dev_head[3:0], tf.cyl_hi, tf.cyl_lo, tf.sec_num};
    wire [15:0] tgt_cyl  = {tf.cyl_hi, tf.cyl_lo};
    wire        out_rng  = lba_sel ? (tgt_lba > MAX_LBA) : (tgt_cyl > MAX_CYL);
    wire [4:0]  x_type   = tf.sec_count[7:3];
    wire [2:0]  x_mode   = tf.sec_count[2:0];
    wire        f_take   = take && is_feat && feat_ok;
    wire        f_sata   = (tf.feature == FT_SATA_ON) || (tf.feature == FT_SATA_OFF);
    wire [7:0]  abt_err  = 8'h01 << ER_ABT;
    wire [7:0]  idn_err  = (8'h01 << ER_IDN) | (8'h01 << ER_ABT);

    // transfer type/mode legality
    always_comb begin
        unique case (x_type)
            XT_PIO_DEF: xfer_ok = (x_mode <= PIO_DEF_MAX);
            XT_PIO_FC:  xfer_ok = (x_mode <= PIO_FC_MAX);
            XT_MDMA:    xfer_ok = (x_mode <= MDMA_MAX);
            XT_UDMA:    xfer_ok = (x_mode <= UDMA_MAX);
            default:    xfer_ok = 1'b0;
        endcase
    end

    // serial sub-feature number to enable bit
    always_comb begin
        sata_ok  = 1'b1;
        sata_bit = 5'h00;
        unique case (tf.sec_count)
            SF_BUF_OFS:  sata_bit = 5'h01;
            SF_AUTO_ACT: sata_bit = 5'h02;
            SF_DIPM:     sata_bit = 5'h04;
            SF_IN_ORDER: sata_bit = 5'h08;
            SF_PRESERVE: sata_bit = 5'h10;
            default:     sata_ok  = 1'b0;
        endcase
    end

    // feature code legality; unknown codes abort
    always_comb begin
        unique case (tf.feature)
            FT_WC_ON, FT_WC_OFF, FT_APM_ON, FT_APM_OFF, FT_PUIS_ON, FT_PUIS_OFF,
            FT_SPINUP, FT_OFS_ON, FT_OFS_OFF, FT_AAM_ON, FT_AAM_OFF,
            FT_HOST_TIME, FT_LA_OFF, FT_LA_ON, FT_REVERT_OFF, FT_REVERT_ON:
                feat_ok = 1'b1;
            FT_XFER:                feat_ok = xfer_ok;
            FT_SATA_ON, FT_SATA_OFF: feat_ok = sata_ok;
            default:                feat_ok = 1'b0;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////
    // sequencing
    always_comb begin
        state_d = state_q;
        unique case (state_q)
            S_IDLE: begin
                if (take) begin
                    state_d = (is_seek && !out_rng) ? S_SEEK : S_DONE;
                end
            end
            S_SEEK: begin
                if (cnt_q == 12'h000) begin
                    state_d = S_DONE;
                end
            end
            S_DONE: state_d = S_IDLE;
            default: state_d = S_IDLE;
        endcase
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            state_q <= S_IDLE;
            cnt_q   <= 12'h000;
        end else begin
            state_q <= state_d;
            if (take) begin
                cnt_q <= SEEK_CNT - 12'h001;
            end else if (state_q == S_SEEK && cnt_q != 12'h000) begin
                cnt_q <= cnt_q - 12'h001;
            end
        end
    end

    // outcome of the taken command, reported at completion
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            fin_err_q  <= 8'h00;
            lba_mode_q <= 1'b0;
        end else if (take) begin
            lba_mode_q <= lba_sel;
            if (is_seek) begin
                fin_err_q <= out_rng ? idn_err : 8'h00;
            end else if (is_feat) begin
                fin_err_q <= feat_ok ? 8'h00 : abt_err;
            end else begin
                fin_err_q <= abt_err;
            end
        end
    end

    // status, error and completion pulse
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            status_q <= ST_RESET;
            error_q  <= 8'h00;
            done_q   <= 1'b0;
        end else begin
            done_q <= (state_q == S_DONE);
            if (take) begin
                status_q <= 8'h01 << ST_BSY;
            end else if (state_q == S_DONE) begin
                status_q <= (8'h01 << ST_RDY) | (8'h01 << ST_DSC)
                          | ((fin_err_q != 8'h00) ? (8'h01 << ST_ERR) : 8'h00);
                error_q  <= fin_err_q;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // seek target and returned position
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            seek_go_q   <= 1'b0;
            seek_cyl_q  <= 16'h0000;
            seek_head_q <= 4'h0;
            cur_lba_q   <= 28'h0000000;
        end else begin
            seek_go_q <= take && is_seek && !out_rng;
            if (take && is_seek && !out_rng) begin
                seek_cyl_q  <= lba_sel ? tgt_lba[23:8] : tgt_cyl;
                seek_head_q <= tf.dev_head[3:0];
                cur_lba_q   <= tgt_lba;
            end
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            r_snum_q <= 8'h00;
            r_clo_q  <= 8'h00;
            r_chi_q  <= 8'h00;
            r_dh_q   <= 8'h00;
        end else if (state_q == S_SEEK && cnt_q == 12'h000) begin
            r_snum_q <= cur_lba_q[7:0];
            r_clo_q  <= cur_lba_q[15:8];
            r_chi_q  <= cur_lba_q[23:16];
            r_dh_q   <= {lba_mode_q ? 4'h4 : 4'h0, cur_lba_q[27:24]};
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // feature settings; a full reassignment area keeps the cache off
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            write_cache_q <= RST_WC;
            look_ahead_q  <= RST_LA;
            revert_q      <= RST_REVERT;
            release_int_q <= RST_REL_INT;
        end else begin
            if (realloc_full) begin
                write_cache_q <= 1'b0;
            end else if (f_take && tf.feature == FT_WC_ON) begin
                write_cache_q <= 1'b1;
            end else if (f_take && tf.feature == FT_WC_OFF) begin
                write_cache_q <= 1'b0;
            end
            if (f_take && tf.feature == FT_LA_OFF) look_ahead_q <= 1'b0;
            if (f_take && tf.feature == FT_LA_ON) look_ahead_q <= 1'b1;
            if (f_take && tf.feature == FT_REVERT_OFF) revert_q <= 1'b0;
            if (f_take && tf.feature == FT_REVERT_ON) revert_q <= 1'b1;
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            apm_en_q      <= 1'b0;
            puis_en_q     <= 1'b0;
            spinup_q      <= 1'b0;
            offset_mode_q <= 1'b0;
            aam_en_q      <= 1'b0;
        end else begin
            spinup_q <= f_take && tf.feature == FT_SPINUP;
            if (f_take && tf.feature == FT_APM_ON) apm_en_q <= 1'b1;
            if (f_take && tf.feature == FT_APM_OFF) apm_en_q <= 1'b0;
            if (f_take && tf.feature == FT_PUIS_ON) puis_en_q <= 1'b1;
            if (f_take && tf.feature == FT_PUIS_OFF) puis_en_q <= 1'b0;
            if (f_take && tf.feature == FT_OFS_ON) offset_mode_q <= 1'b1;
            if (f_take && tf.feature == FT_OFS_OFF) offset_mode_q <= 1'b0;
            if (f_take && tf.feature == FT_AAM_ON) aam_en_q <= 1'b1;
            if (f_take && tf.feature == FT_AAM_OFF) aam_en_q <= 1'b0;
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            xfer_type_q <= XT_PIO_DEF;
            xfer_mode_q <= 3'h0;
            iordy_off_q <= 1'b0;
            sata_en_q   <= 5'h00;
            host_time_q <= 32'h00000000;
        end else if (f_take) begin
            if (tf.feature == FT_XFER) begin
                xfer_type_q <= x_type;
                xfer_mode_q <= x_mode;
                iordy_off_q <= (x_type == XT_PIO_DEF) && (x_mode == PIO_DEF_MAX);
            end
            if (f_sata) begin
                sata_en_q <= (tf.feature == FT_SATA_ON) ? (sata_en_q | sata_bit)
                                                        : (sata_en_q & ~sata_bit);
            end
            if (tf.feature == FT_HOST_TIME) begin
                host_time_q <= {tf.cyl_hi, tf.cyl_lo, tf.sec_num, tf.sec_count};
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    assign tf.done         = done_q;
    assign tf.status       = status_q;
    assign tf.error        = error_q;
    assign tf.ret_sec_num  = r_snum_q;
    assign tf.ret_cyl_lo   = r_clo_q;
    assign tf.ret_cyl_hi   = r_chi_q;
    assign tf.ret_dev_head = r_dh_q;
endmodule

/* hw/disk_cmd_host.sv */
// host-side task-file controller, reached over classic wishbone
`timescale 1ns/1ps
module disk_cmd_host
    import tf_pkg::*;
(
    // clock and reset
    input  wire logic        mclk,
    input  wire logic        rst_n,
    // wishbone slave
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic [31:0]      wb_dat_o,
    output logic             wb_ack_o,
    // task-file link
    taskfile_if.host         tf
);
    logic [7:0] regs_q [6];
    logic [7:0] cmd_q;
    logic       valid_q;
    logic       pend_q;
    logic       done_q;
    logic [7:0] rd_sel;

    ////////////////////////////////////////////////////////////////////////////
    wire       req    = wb_cyc_i && wb_stb_i && !wb_ack_o;
    wire       wr     = req && wb_we_i && wb_sel_i[0];
    wire       par_hit = (wb_adr_i <= A_DH) && (wb_adr_i[1:0] == 2'b00);
    wire [2:0] par_ix = wb_adr_i[4:2];
    wire       go     = wr && (wb_adr_i == A_CMD) && !pend_q;
    wire       clr    = req && wb_we_i && wb_sel_i[2] && (wb_adr_i == A_STAT)
                      && wb_dat_i[HS_DONE];
    wire [31:0] stat_word = {14'h0000, pend_q, done_q, tf.error, tf.status};

    always_comb begin
        unique case (par_ix)
            3'h2:    rd_sel = tf.ret_sec_num;
            3'h3:    rd_sel = tf.ret_cyl_lo;
            3'h4:    rd_sel = tf.ret_cyl_hi;
            3'h5:    rd_sel = tf.ret_dev_head;
            default: rd_sel = 8'h00;
        endcase
    end

    wire [31:0] rd_word = par_hit ? {16'h0000, rd_sel, regs_q[par_ix]} :
                          (wb_adr_i == A_CMD)  ? {24'h000000, cmd_q} :
                          (wb_adr_i == A_STAT) ? stat_word : 32'h00000000;

    // parameter registers; writes while a command runs are still taken
    genvar gi;
    generate
        for (gi = 0; gi < 6; gi++) begin : g_par
            always_ff @(posedge mclk or negedge rst_n) begin
                if (!rst_n) begin
                    regs_q[gi] <= 8'h00;
                end else if (wr && par_hit && par_ix == 3'(gi)) begin
                    regs_q[gi] <= wb_dat_i[7:0];
                end
            end
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////
    // one request per ack; every access is answered, unmapped reads give zero
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h00000000;
        end else begin
            wb_ack_o <= req;
            wb_dat_o <= req ? rd_word : 32'h00000000;
        end
    end

    // command launch; a command write while the previous one is pending is dropped
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            cmd_q   <= 8'h00;
            valid_q <= 1'b0;
            pend_q  <= 1'b0;
            done_q  <= 1'b0;
        end else begin
            valid_q <= go;
            if (go) begin
                cmd_q <= wb_dat_i[7:0];
            end
            if (go) begin
                pend_q <= 1'b1;
            end else if (tf.done) begin
                pend_q <= 1'b0;
            end
            if (tf.done) begin
                done_q <= 1'b1;
            end else if (clr) begin
                done_q <= 1'b0;
            end
        end
    end

    assign tf.cmd_valid = valid_q;
    assign tf.cmd       = cmd_q;
    assign tf.feature   = regs_q[0];
    assign tf.sec_count = regs_q[1];
    assign tf.sec_num   = regs_q[2];
    assign tf.cyl_lo    = regs_q[3];
    assign tf.cyl_hi    = regs_q[4];
    assign tf.dev_head  = regs_q[5];
endmodule

/* bench/tf_checker.sv */
// concurrent checks on the task-file link between the two ends
`timescale 1ns/1ps
module tf_checker
    import tf_pkg::*;
(
    // clock, reset and host side
    input wire logic       mclk,
    input wire logic       rst_n,
    input wire logic       cmd_valid,
    input wire logic [7:0] cmd,
    input wire logic [7:0] feature,
    input wire logic [7:0] cyl_hi,
    input wire logic [7:0] dev_head,
    // drive side
    input wire logic       done,
    input wire logic [7:0] status,
    input wire logic [7:0] error
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);
    // a non-zero head nibble in lba mode always lies past the last block
    wire is_seek = cmd[7:4] == CMD_SEEK_NIB && dev_head[DH_LBA];
    wire far_lba = is_seek && dev_head[3:0] != 4'h0;
    wire ok_lba  = is_seek && dev_head[3:0] == 4'h0 && cyl_hi != 8'hff;
    ////////////////////////////////////////////////////////////////////////////
    chk_busy_on_take: assert property (cmd_valid |=> status == 8'h80)
        else $error("busy not shown");
    // done and final status both follow the second edge after the take
    chk_feat_done: assert property (cmd_valid && cmd == CMD_SET_FEAT |-> ##2 done)
        else $error("feature done late");
    chk_bad_feat: assert property (cmd_valid && cmd == CMD_SET_FEAT && feature == 8'h01
        |-> ##2 error == 8'h04 && status == 8'h51) else $error("bad code not aborted");
    chk_seek_range: assert property (cmd_valid && far_lba |-> ##2 error == 8'h14)
        else $error("far seek not refused");
    chk_seek_time: assert property (cmd_valid && ok_lba |-> ##[190:210] done)
        else $error("seek done missing");
    chk_done_pulse: assert property (done |=> !done)
        else $error("done too long");
    chk_done_ready: assert property (done |-> status[ST_RDY] && !status[ST_BSY]
        && status[ST_ERR] == error[ER_ABT]) else $error("bad final status");
    chk_reset_state: assert property ($rose(rst_n) |-> status == ST_RESET
        && error == 8'h00) else $error("bad reset status");
    cover property (cmd_valid && ok_lba);
    cover property (cmd_valid && far_lba);
    cover property (done && status[ST_ERR]);
endmodule

/* bench/tb_top.sv */
// self-checking bench: wishbone host end driving the drive end
`timescale 1ns/1ps
module tb_top
    import tf_pkg::*;
;
    logic        mclk, rst_n, realloc_full, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
    logic        seek_go_q, write_cache_q, look_ahead_q, revert_q, release_int_q, apm_en_q;
    logic        puis_en_q, spinup_q, offset_mode_q, aam_en_q, iordy_off_q;
    logic [3:0]  wb_sel_i, seek_head_q;
    logic [7:0]  wb_adr_i;
    logic [15:0] seek_cyl_q;
    logic [27:0] cur_lba_q;
    logic [4:0]  xfer_type_q, sata_en_q;
    logic [2:0]  xfer_mode_q;
    logic [31:0] wb_dat_i, wb_dat_o, rd_q, st_q, host_time_q;
    int          errors = 0;
    int          tests_run = 0;
    int          go_seen = 0;
    int          spin_seen = 0;
    wire  [6:0]  sense = {write_cache_q, look_ahead_q, revert_q, apm_en_q, puis_en_q,
                          offset_mode_q, aam_en_q};
    // one-cycle pulses are counted here, the tasks only see levels
    always @(posedge mclk) begin
        go_seen   <= go_seen + int'(seek_go_q);
        spin_seen <= spin_seen + int'(spinup_q);
    end
    taskfile_if tf ();
    disk_cmd_host disk_cmd_host_inst (.tf(tf.host), .*);
    disk_cmd_device disk_cmd_device_inst (.tf(tf.dev), .*);
    tf_checker tf_checker_inst (.mclk(mclk), .rst_n(rst_n), .cmd_valid(tf.cmd_valid),
        .cmd(tf.cmd), .feature(tf.feature), .cyl_hi(tf.cyl_hi), .dev_head(tf.dev_head),
        .done(tf.done), .status(tf.status), .error(tf.error));
    ////////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            errors++;
            $display("BAD %0t seen %h want %h", $time, seen, exp);
        end
    endtask
    task automatic bus(input logic we, input logic [7:0] a, input logic [31:0] d);
        int n = 0;
        {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} <= {2'b11, we, a, d};
        do begin
            @(posedge mclk);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 99);
        if (wb_ack_o !== 1'b1) errors++;
        rd_q = wb_dat_o;
        {wb_cyc_i, wb_stb_i} <= 2'b00;
        @(posedge mclk);
    endtask
    // v = {command, feature, count, sector, cyl lo, cyl hi, dev/head, expected error}
    task automatic run(input logic [63:0] v);
        int n = 0;
        for (int k = 0; k < 6; k++) bus(1'b1, 8'(4 * k), {24'h0, v[55 - 8 * k -: 8]});
        bus(1'b1, A_CMD, {24'h0, v[63:56]});
        do begin
            bus(1'b0, A_STAT, 32'h0);
            n++;
        end while (rd_q[HS_DONE] !== 1'b1 && n < 300);
        if (rd_q[HS_DONE] !== 1'b1) errors++;
        st_q = rd_q;
        bus(1'b1, A_STAT, 32'h0001_0000);
        chk({16'h0, st_q[15:0]}, {16'h0, v[7:0], 7'h28, |v[7:0]});
    endtask
    task automatic end_of_test();
        $display("errors %0d tests_run %0d", errors, tests_run);
        if (errors == 0 && tests_run > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end
    initial begin
        #200000;
        errors++;
        end_of_test();
    end
    initial begin
        static logic [15:0] pr [7] = '{16'h0282, 16'haa55, 16'hcc66, 16'h0585, 16'h0686,
                                       16'h0989, 16'h42c2};
        static logic [7:0]  xf [4] = '{8'h46, 8'h0c, 8'h22, 8'h01};
        static logic [7:0]  sf [5] = '{8'h01, 8'h02, 8'h03, 8'h04, 8'h06};
        {rst_n, realloc_full, wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i} = 13'h0;
        wb_sel_i = 4'hf;
        wb_dat_i = 32'h0;
        repeat (16) @(posedge mclk);
        rst_n <= 1'b1;
        @(posedge mclk);
        chk({28'h0, write_cache_q, look_ahead_q, revert_q, release_int_q}, 32'hc);
        bus(1'b0, A_STAT, 32'h0);
        chk(rd_q, 32'h50);
        bus(1'b1, 8'h40, 32'h5a);
        bus(1'b0, 8'h40, 32'h0);
        chk(rd_q, 32'h0);
        for (int i = 0; i < 7; i++) begin
            run({8'hef, pr[i][15:8], 48'h0});
            chk({31'h0, sense[6 - i]}, 32'h1);
            run({8'hef, pr[i][7:0], 48'h0});
            chk({31'h0, sense[6 - i]}, 32'h0);
        end
        run(64'hef07_0000_0000_0000);
        chk(spin_seen, 32'h1);
        run(64'hef01_0000_0000_0004);
        run(64'hef43_1100_0000_0000);
        chk(host_time_q, 32'h11);
        for (int i = 0; i < 4; i++) begin
            run({16'hef03, xf[i], 40'h0});
            chk({24'h0, xfer_type_q, xfer_mode_q}, {24'h0, xf[i]});
        end
        chk({31'h0, iordy_off_q}, 32'h1);
        run(64'hef03_2300_0000_0004);
        for (int i = 0; i < 5; i++) run({16'hef10, sf[i], 40'h0});
        chk({27'h0, sata_en_q}, 32'h1f);
        run(64'hef90_0300_0000_0000);
        chk({27'h0, sata_en_q}, 32'h1b);
        run(64'hef10_0500_0000_0004);
        // cache must be on first, or the forced-off case proves nothing
        run(64'hef02_0000_0000_0000);
        chk({31'h0, write_cache_q}, 32'h1);
        realloc_full <= 1'b1;
        run(64'hef02_0000_0000_0000);
        chk({31'h0, write_cache_q}, 32'h0);
        realloc_full <= 1'b0;
        run(64'h7a00_0012_3456_e000);
        chk({4'h0, cur_lba_q}, 32'h0563412);
        chk({12'h0, seek_cyl_q, seek_head_q}, 32'h56340);
        for (int k = 0; k < 4; k++) begin
            bus(1'b0, 8'(8 + 4 * k), 32'h0);
            chk({24'h0, rd_q[15:8]}, {24'h0, 8'(32'h40563412 >> (8 * k))});
        end
        run(64'h7000_0009_0201_a300);
        chk({12'h0, seek_cyl_q, seek_head_q}, 32'h01023);
        run(64'h7f00_0000_0000_e514);
        chk({4'h0, cur_lba_q}, 32'h3010209);
        chk(go_seen, 32'h2);
        run(64'h2000_0000_0000_0004);
        end_of_test();
    end
endmodule
